//--- hdl/ppc_regs.svh
// What this block does
// - Channel count zero: P-Channel; else Q-Channels.
// - Mode count 0-15; with Q-Channels ignored except by the interrupt-option checks.
// - Activity model picks ladder or independent decoding.
// - Ladder model needs one to eight modes.
// - Independent model needs 1, 3, 7 or 15.
// - Operating-done interrupt option needs modes present.
// - Power-done interrupt option needs modes present.
// - Lock option needs a dynamic low-power mode.
// - Device delay writes work only when enabled.
// - Entry delay writes work only when enabled.
// - Debug-recovery support only with P-Channel.
// - Dynamic off needs dynamic on.
// - Dynamic off-emulation needs on, static emulation, off.
// - Dynamic retention needs on, static; forced by default.
//
// Purpose: Register offsets, field positions, reset values and mode codes.
// Assumes: 32-bit AXI4-Lite register window, word aligned.
// Notes: Definitions only.
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PPC_OFS_CONFIG 8'h00
`define PPC_OFS_PWR_POLICY 8'h04
`define PPC_OFS_OP_POLICY 8'h08
`define PPC_OFS_STATUS 8'h0c
`define PPC_OFS_INT_STATUS 8'h10
`define PPC_OFS_INT_MASK 8'h14
`define PPC_OFS_LOCK 8'h18
`define PPC_OFS_ACTIVITY 8'h1c
`define PPC_OFS_DEV_DELAY_A 8'h20
`define PPC_OFS_DEV_DELAY_B 8'h24
`define PPC_OFS_ENTRY_DELAY_A 8'h28
`define PPC_OFS_ENTRY_DELAY_B 8'h2c

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define PPC_POLICY_W 4
`define PPC_DYN_EN_BIT 8
`define PPC_STAT_OP_LSB 4
`define PPC_STAT_LOCK_BIT 8
`define PPC_INT_OP_DONE 0
`define PPC_INT_PWR_DONE 1
`define PPC_INT_ACTIVITY 2
`define PPC_INT_W 3
`define PPC_ACT_LSB 16
`define PPC_QCHAN_MAX 8

// ----------------------------------------------------------------
// Power mode codes and reset values
// ----------------------------------------------------------------
`define PPC_MODE_OFF 4'h0
`define PPC_MODE_OFF_EMU 4'h1
`define PPC_MODE_MEM_RET 4'h2
`define PPC_MODE_MEM_RET_EMU 4'h3
`define PPC_MODE_DBG_RECOV 4'h6
`define PPC_MODE_ON 4'h8
`define PPC_RST_PWR_POLICY 4'h0
`define PPC_RST_DELAY 32'h0000_0000

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define PPC_RESP_OKAY 2'h0
`define PPC_RESP_DECERR 2'h3

`endif

//--- hdl/ppc_pkg.sv
// Purpose: Types shared by the power policy configuration block.
// Assumes: Constants come from ppc_regs.svh.
// Notes: Types only.
package ppc_pkg;

	typedef enum logic {
		ppc_ladder,
		ppc_independent
	} ppc_model_type;

	typedef struct packed {
		logic en;
		logic [1:0] idx;
		logic [31:0] data;
		logic [3:0] strb;
	} ppc_delay_wr_type;

	typedef struct packed {
		logic activity;
		logic pwr_done;
		logic op_done;
	} ppc_irq_type;

endpackage : ppc_pkg

//--- hdl/ppc_delay_bank.sv
// Purpose: Device-control and entry delay registers.
// Assumes: Words 0-1 are device delays, words 2-3 entry delays.
// Notes: Writes to a locked-out pair are dropped silently.
`timescale 1ns/10ps
`include "ppc_regs.svh"
module ppc_delay_bank #(
	parameter logic SW_DEV_OPTION = 1'b0,
	parameter logic ENTRY_OPTION = 1'b0,
	parameter logic [127:0] DEFAULTS = {4{`PPC_RST_DELAY}}
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire ppc_pkg::ppc_delay_wr_type wr,
	output logic [3:0][31:0] words
);

	// ----------------------------------------------------------------
	// Word storage
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_word
			localparam logic ALLOWED = (gi < 2) ? SW_DEV_OPTION : ENTRY_OPTION;
			logic hit;
			logic [31:0] next_word;
			assign hit = wr.en && (wr.idx == 2'(gi)) && ALLOWED;
			genvar bi;
			for (bi = 0; bi < 4; bi = bi + 1) begin : g_byte
				assign next_word[bi*8 +: 8] = wr.strb[bi] ? wr.data[bi*8 +: 8] : words[gi][bi*8 +: 8];
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					words[gi] <= DEFAULTS[gi*32 +: 32];
				end else if (hit) begin
					words[gi] <= next_word;
				end
			end
		end
	endgenerate

endmodule : ppc_delay_bank

//--- hdl/ppc_top.sv
// Purpose: Power policy controller configuration and policy register layer.
// Assumes: Single clock; AXI4-Lite slave; activity inputs synchronous.
// Notes: Build options are checked at elaboration.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "ppc_regs.svh"
module ppc_top #(
	parameter int unsigned DEVICE_CHANNEL_COUNT = 0,
	parameter int unsigned OPERATING_MODE_COUNT = 4,
	parameter logic OPERATING_ACTIVITY_MODEL = 1'b0,
	parameter logic OP_POLICY_DONE_IRQ_OPTION = 1'b1,
	parameter logic PWR_POLICY_DONE_IRQ_OPTION = 1'b1,
	parameter logic LOCK_OPTION = 1'b1,
	parameter logic SOFTWARE_DEVICE_DELAY_OPTION = 1'b1,
	parameter logic ENTRY_DELAY_OPTION = 1'b1,
	parameter logic STATIC_OFF_EMULATION_SUPPORT = 1'b1,
	parameter logic STATIC_MEMORY_RETENTION_SUPPORT = 1'b1,
	parameter logic STATIC_DEBUG_RECOVERY_SUPPORT = 1'b0,
	parameter logic DYNAMIC_ON_SUPPORT = 1'b1,
	parameter logic DYNAMIC_OFF_SUPPORT = 1'b1,
	parameter logic DYNAMIC_OFF_EMULATION_SUPPORT = 1'b0,
	parameter logic DYNAMIC_MEMORY_RETENTION_SUPPORT = 1'b1,
	parameter logic DYNAMIC_MEMRET_EMULATION_SUPPORT = 1'b0,
	parameter logic DEFAULT_DYNAMIC_POWER_ENABLE = 1'b0,
	parameter logic OFF_TO_MEMRET_TRANSITION_OPTION = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] pactive,
	output logic pchannel_en,
	output logic [7:0] qchannel_en,
	output logic [3:0] power_mode,
	output logic [3:0] operating_mode,
	output logic irq
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	localparam bit HAS_OPMODES = (DEVICE_CHANNEL_COUNT == 0) && (OPERATING_MODE_COUNT != 0);
	generate
		if (DEVICE_CHANNEL_COUNT > 8) begin : g_bad_chan
			$error("device channel count out of range");
		end
		if (OPERATING_MODE_COUNT > 15) begin : g_bad_count
			$error("operating mode count out of range");
		end
		if (HAS_OPMODES && !OPERATING_ACTIVITY_MODEL && (OPERATING_MODE_COUNT > 8)) begin : g_bad_ld
			$error("ladder model needs one to eight modes");
		end
		if (HAS_OPMODES && OPERATING_ACTIVITY_MODEL &&
			!(OPERATING_MODE_COUNT inside {1, 3, 7, 15})) begin : g_bad_ind
			$error("independent model needs 1, 3, 7 or 15 modes");
		end
		if ((OPERATING_MODE_COUNT == 0) && OP_POLICY_DONE_IRQ_OPTION) begin : g_bad_opirq
			$error("operating done interrupt needs operating modes");
		end
		if ((OPERATING_MODE_COUNT == 0) && PWR_POLICY_DONE_IRQ_OPTION) begin : g_bad_pwirq
			$error("power done interrupt needs operating modes");
		end
		if (LOCK_OPTION && !(DYNAMIC_OFF_SUPPORT || DYNAMIC_OFF_EMULATION_SUPPORT ||
			DYNAMIC_MEMORY_RETENTION_SUPPORT || DYNAMIC_MEMRET_EMULATION_SUPPORT)) begin : g_bad_lock
			$error("lock needs a dynamic low-power mode");
		end
		if (STATIC_DEBUG_RECOVERY_SUPPORT && (DEVICE_CHANNEL_COUNT != 0)) begin : g_bad_dbg
			$error("debug recovery needs the P-Channel interface");
		end
		if (DYNAMIC_OFF_SUPPORT && !DYNAMIC_ON_SUPPORT) begin : g_bad_doff
			$error("dynamic off needs dynamic on");
		end
		if (DYNAMIC_OFF_EMULATION_SUPPORT && !(DYNAMIC_ON_SUPPORT &&
			STATIC_OFF_EMULATION_SUPPORT && DYNAMIC_OFF_SUPPORT)) begin : g_bad_demu
			$error("dynamic off emulation prerequisites missing");
		end
		if (DYNAMIC_MEMORY_RETENTION_SUPPORT &&
			!(DYNAMIC_ON_SUPPORT && STATIC_MEMORY_RETENTION_SUPPORT)) begin : g_bad_dret
			$error("dynamic retention prerequisites missing");
		end
		if (!DYNAMIC_MEMORY_RETENTION_SUPPORT && DEFAULT_DYNAMIC_POWER_ENABLE &&
			OFF_TO_MEMRET_TRANSITION_OPTION) begin : g_need_dret
			$error("dynamic retention required by default settings");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_COUNT = 4'(OPERATING_MODE_COUNT);
	localparam logic [3:0] CHAN_COUNT = 4'(DEVICE_CHANNEL_COUNT);

	function automatic logic [3:0] reg_index(input logic [7:0] addr);
		reg_index = addr[5:2];
	endfunction : reg_index

	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr[7:6] == 2'h0) && (addr[5:2] <= `PPC_OFS_ENTRY_DELAY_B >> 2);
	endfunction : mapped

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge

	function automatic logic mode_supported(input logic [3:0] mode);
		unique case (mode)
			`PPC_MODE_OFF: mode_supported = 1'b1;
			`PPC_MODE_ON: mode_supported = 1'b1;
			`PPC_MODE_OFF_EMU: mode_supported = STATIC_OFF_EMULATION_SUPPORT;
			`PPC_MODE_MEM_RET: mode_supported = STATIC_MEMORY_RETENTION_SUPPORT;
			`PPC_MODE_DBG_RECOV: mode_supported = STATIC_DEBUG_RECOVERY_SUPPORT;
			default: mode_supported = 1'b0;
		endcase
	endfunction : mode_supported

	// ----------------------------------------------------------------
	// Activity decoding
	// ----------------------------------------------------------------
	logic [15:0] act_hi;
	logic [3:0] ladder_mode;
	logic [3:0] indep_mode;
	logic [3:0] next_act_mode;
	assign act_hi = pactive[31:`PPC_ACT_LSB];

	always_comb begin
		ladder_mode = 4'h0;
		for (int i = 0; i < 8; i++) begin
			if (act_hi[i] && (4'(i) < OP_COUNT)) begin
				ladder_mode = 4'(i + 1);
			end
		end
	end

	assign indep_mode = act_hi[3:0] & OP_COUNT;
	assign next_act_mode = !HAS_OPMODES ? 4'h0 :
		(ppc_pkg::ppc_model_type'(OPERATING_ACTIVITY_MODEL) == ppc_pkg::ppc_ladder) ?
		ladder_mode : indep_mode;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic [7:0] aw_addr;
	logic aw_full;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_full;
	logic do_write;
	logic do_read;
	logic [3:0] wr_idx;
	logic [3:0] rd_idx;
	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign wr_idx = reg_index(aw_addr);
	assign rd_idx = reg_index(s_axi_araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PPC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_full <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_full <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(aw_addr) ? `PPC_RESP_OKAY : `PPC_RESP_DECERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Policy, lock and interrupt registers
	// ----------------------------------------------------------------
	logic [3:0] pwr_policy;
	logic dyn_en;
	logic [3:0] op_policy;
	logic locked;
	logic [2:0] int_status;
	logic [2:0] int_mask;
	logic [3:0] act_mode;
	logic [31:0] wr_merged;
	logic [31:0] rd_old;
	logic pwr_wr_ok;
	logic op_wr_ok;
	ppc_pkg::ppc_irq_type events;
	logic [2:0] next_int_status;

	assign pwr_wr_ok = do_write && (wr_idx == (`PPC_OFS_PWR_POLICY >> 2)) && !locked &&
		mode_supported(wr_merged[3:0]);
	assign op_wr_ok = do_write && (wr_idx == (`PPC_OFS_OP_POLICY >> 2)) && HAS_OPMODES;
	assign wr_merged = merge(rd_old, w_data, w_strb);
	assign events.op_done = OP_POLICY_DONE_IRQ_OPTION && (operating_mode != op_policy);
	assign events.pwr_done = PWR_POLICY_DONE_IRQ_OPTION && (power_mode != pwr_policy);
	assign events.activity = act_mode != next_act_mode;
	assign next_int_status = (do_write && (wr_idx == (`PPC_OFS_INT_STATUS >> 2)) ?
		(int_status & ~wr_merged[2:0]) : int_status) | events;

	always_comb begin
		unique case (wr_idx)
			4'(`PPC_OFS_PWR_POLICY >> 2): rd_old = {23'h0, dyn_en, 4'h0, pwr_policy};
			4'(`PPC_OFS_OP_POLICY >> 2): rd_old = {28'h0, op_policy};
			4'(`PPC_OFS_INT_MASK >> 2): rd_old = {29'h0, int_mask};
			4'(`PPC_OFS_LOCK >> 2): rd_old = {31'h0, locked};
			default: rd_old = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_policy <= `PPC_RST_PWR_POLICY;
			dyn_en <= DEFAULT_DYNAMIC_POWER_ENABLE & DYNAMIC_ON_SUPPORT;
			op_policy <= 4'h0;
			locked <= 1'b0;
			int_mask <= 3'h0;
			int_status <= 3'h0;
			act_mode <= 4'h0;
			power_mode <= `PPC_RST_PWR_POLICY;
			operating_mode <= 4'h0;
			irq <= 1'b0;
			pchannel_en <= 1'b0;
			qchannel_en <= 8'h00;
		end else begin
			if (pwr_wr_ok) begin
				pwr_policy <= wr_merged[3:0];
				dyn_en <= wr_merged[`PPC_DYN_EN_BIT] & DYNAMIC_ON_SUPPORT;
			end
			if (op_wr_ok) begin
				op_policy <= (wr_merged[3:0] > OP_COUNT) ? OP_COUNT : wr_merged[3:0];
			end
			if (do_write && (wr_idx == (`PPC_OFS_LOCK >> 2))) begin
				locked <= wr_merged[0] & LOCK_OPTION;
			end
			if (do_write && (wr_idx == (`PPC_OFS_INT_MASK >> 2))) begin
				int_mask <= wr_merged[2:0];
			end
			int_status <= next_int_status;
			act_mode <= next_act_mode;
			power_mode <= pwr_policy;
			operating_mode <= op_policy;
			irq <= |(next_int_status & int_mask);
			pchannel_en <= (CHAN_COUNT == 4'h0);
			for (int i = 0; i < `PPC_QCHAN_MAX; i++) begin
				qchannel_en[i] <= (4'(i) < CHAN_COUNT);
			end
		end
	end

	// ----------------------------------------------------------------
	// Delay registers
	// ----------------------------------------------------------------
	ppc_pkg::ppc_delay_wr_type delay_wr;
	logic [3:0][31:0] delay_words;
	assign delay_wr.en = do_write && (wr_idx >= (`PPC_OFS_DEV_DELAY_A >> 2)) && mapped(aw_addr);
	assign delay_wr.idx = wr_idx[1:0];
	assign delay_wr.data = w_data;
	assign delay_wr.strb = w_strb;

	ppc_delay_bank #(
		.SW_DEV_OPTION(SOFTWARE_DEVICE_DELAY_OPTION),
		.ENTRY_OPTION(ENTRY_DELAY_OPTION)
	) u_delay (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr(delay_wr),
		.words(delay_words)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [31:0] config_word;
	logic [31:0] rd_word;
	assign config_word = {12'h0, DYNAMIC_MEMORY_RETENTION_SUPPORT, DYNAMIC_OFF_SUPPORT,
		DYNAMIC_ON_SUPPORT, ENTRY_DELAY_OPTION, SOFTWARE_DEVICE_DELAY_OPTION, LOCK_OPTION,
		PWR_POLICY_DONE_IRQ_OPTION, OP_POLICY_DONE_IRQ_OPTION, 3'h0,
		OPERATING_ACTIVITY_MODEL, OP_COUNT, CHAN_COUNT};

	always_comb begin
		unique case (rd_idx)
			4'(`PPC_OFS_CONFIG >> 2): rd_word = config_word;
			4'(`PPC_OFS_PWR_POLICY >> 2): rd_word = {23'h0, dyn_en, 4'h0, pwr_policy};
			4'(`PPC_OFS_OP_POLICY >> 2): rd_word = {28'h0, op_policy};
			4'(`PPC_OFS_STATUS >> 2): rd_word = {23'h0, locked, operating_mode, power_mode};
			4'(`PPC_OFS_INT_STATUS >> 2): rd_word = {29'h0, int_status};
			4'(`PPC_OFS_INT_MASK >> 2): rd_word = {29'h0, int_mask};
			4'(`PPC_OFS_LOCK >> 2): rd_word = {31'h0, locked};
			4'(`PPC_OFS_ACTIVITY >> 2): rd_word = {28'h0, act_mode};
			4'(`PPC_OFS_DEV_DELAY_A >> 2): rd_word = delay_words[0];
			4'(`PPC_OFS_DEV_DELAY_B >> 2): rd_word = delay_words[1];
			4'(`PPC_OFS_ENTRY_DELAY_A >> 2): rd_word = delay_words[2];
			4'(`PPC_OFS_ENTRY_DELAY_B >> 2): rd_word = delay_words[3];
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `PPC_RESP_OKAY;
		end else if (do_read) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= mapped(s_axi_araddr) ? rd_word : 32'h0000_0000;
			s_axi_rresp <= mapped(s_axi_araddr) ? `PPC_RESP_OKAY : `PPC_RESP_DECERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule : ppc_top

//--- testbench/ppc_top_monitor.sv
// Purpose: Port checker for the power policy configuration block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound into ppc_top after the module.
`timescale 1ns/10ps
module ppc_top_monitor #(
	parameter int unsigned DEVICE_CHANNEL_COUNT = 0,
	parameter int unsigned OPERATING_MODE_COUNT = 4,
	parameter logic STATIC_DEBUG_RECOVERY_SUPPORT = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pchannel_en,
	input wire logic [7:0] qchannel_en,
	input wire logic [3:0] power_mode,
	input wire logic [3:0] operating_mode,
	input wire logic irq
);
	logic [7:0] qmask;

	assign qmask = 8'((16'h1 << DEVICE_CHANNEL_COUNT) - 16'h1);

	default clocking mon_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_PCHAN_SELECT: assert property ($past(aresetn) |->
		pchannel_en == (DEVICE_CHANNEL_COUNT == 0))
		else $error("p-channel enable disagrees with channel count");
	AST_QCHAN_SELECT: assert property ($past(aresetn) |-> qchannel_en == qmask)
		else $error("q-channel enables disagree with channel count");
	AST_OPMODE_BOUND: assert property (operating_mode <= 4'(OPERATING_MODE_COUNT))
		else $error("operating mode above configured count");
	AST_NO_DBG_RECOV: assert property (!STATIC_DEBUG_RECOVERY_SUPPORT |->
		power_mode != 4'h6)
		else $error("debug recovery mode entered without support");
	AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read answer not on next cycle");
	AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before acceptance");
	AST_WRITE_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channels open during response");
	AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before acceptance");

	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($rose(irq));
	cover property ($changed(power_mode));
endmodule : ppc_top_monitor

bind ppc_top ppc_top_monitor #(.DEVICE_CHANNEL_COUNT(DEVICE_CHANNEL_COUNT),
	.OPERATING_MODE_COUNT(OPERATING_MODE_COUNT),
	.STATIC_DEBUG_RECOVERY_SUPPORT(STATIC_DEBUG_RECOVERY_SUPPORT)) u_monitor (.aclk, .aresetn,
	.s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pchannel_en, .qchannel_en,
	.power_mode, .operating_mode, .irq);

//--- testbench/ppc_device_model.sv
// Purpose: Behavioural power-controlled device on the activity inputs.
// Assumes: Bench sets the operating demand.
// Notes: Reports activity for its current power mode only on a P-Channel.
`timescale 1ns/10ps
module ppc_device_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pchannel_en,
	input wire logic [3:0] power_mode,
	input wire logic [15:0] op_demand,
	output logic [31:0] pactive
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pactive <= 32'h0000_0000;
		end else begin
			pactive[31:16] <= op_demand;
			pactive[15:0] <= pchannel_en ? 16'(16'h1 << power_mode) : 16'h0000;
		end
	end
endmodule : ppc_device_model

//--- testbench/power_policy_config_params_tb.sv
// Purpose: Self-checking bench for the power policy configuration block.
// Assumes: Default build options of ppc_top.
// Notes: Bus results are queued by the drivers and compared on acceptance.
`timescale 1ns/10ps
`define CHK(got, exp) check_val(34'(got), 34'(exp), 34'h3_ffff_ffff)
module power_policy_config_params_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, pactive;
	logic pchannel_en, irq;
	logic [7:0] qchannel_en;
	logic [3:0] power_mode, operating_mode;
	logic [15:0] op_demand;
	logic [67:0] pending[$];
	logic [67:0] entry;
	logic [31:0] rnd[4];
	logic [3:0] op_set[4] = '{4'h0, 4'h2, 4'h4, 4'hf};
	logic [3:0] op_exp[4] = '{4'h0, 4'h2, 4'h4, 4'h4};
	logic [3:0] pwr_set[4] = '{4'h0, 4'h1, 4'h2, 4'h8};
	int miscompares = 0;
	int checked = 0;
	int seed = 61;

	ppc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pactive, .pchannel_en, .qchannel_en, .power_mode,
		.operating_mode, .irq);

	ppc_device_model partner (.aclk, .aresetn, .pchannel_en, .power_mode, .op_demand, .pactive);

	initial begin
		forever #20 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check_val(input logic [33:0] got, input logic [33:0] exp,
		input logic [33:0] mask);
		checked++;
		if ((got & mask) !== (exp & mask)) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got & mask, exp & mask);
		end
	endtask : check_val

	task close_out;
		if (pending.size() != 0) miscompares++;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out

	task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		pending.push_back({34'h3_0000_0000, resp, 32'h0000_0000});
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task axi_read(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] resp);
		pending.push_back({2'h3, m, resp, d});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : axi_read

	task wait_irq(input logic v);
		for (int k = 0; k < 20 && irq !== v; k++) @(posedge aclk);
	endtask : wait_irq

	task wait_modes(input logic [3:0] pm, input logic [3:0] om);
		for (int k = 0; k < 20 && (power_mode !== pm || operating_mode !== om); k++) @(posedge aclk);
	endtask : wait_modes

	always @(posedge aclk) begin
		if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
			entry = pending.pop_front();
			check_val(s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0000_0000},
				entry[33:0], entry[67:34]);
		end
	end

	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		$display("timeout at %0t", $time);
		close_out;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		op_demand = 16'h0000;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		`CHK(pchannel_en, 1'b1);
		`CHK(qchannel_en, 8'h00);
		axi_read(8'h00, 32'h000f_f040, 32'hffff_ffff, 2'h0);
		$display("test configuration done");
		for (int i = 0; i < 4; i++) begin
			rnd[i] = $random(seed);
			axi_write(8'h20 + 8'(4 * i), rnd[i], 2'h0);
		end
		for (int i = 0; i < 4; i++) begin
			axi_read(8'h20 + 8'(4 * i), rnd[i], 32'hffff_ffff, 2'h0);
		end
		axi_write(8'h30, 32'h0000_0001, 2'h3);
		axi_read(8'h30, 32'h0000_0000, 32'hffff_ffff, 2'h3);
		$display("test delay registers done");
		axi_write(8'h14, 32'h0000_0004, 2'h0);
		axi_write(8'h10, 32'h0000_0007, 2'h0);
		for (int i = 0; i < 4; i++) begin
			op_demand <= 16'(16'h1 << i);
			wait_irq(1'b1);
			`CHK(irq, 1'b1);
			axi_read(8'h1c, 32'(i + 1), 32'h0000_000f, 2'h0);
			axi_write(8'h10, 32'h0000_0004, 2'h0);
			wait_irq(1'b0);
			`CHK(irq, 1'b0);
		end
		axi_write(8'h14, 32'h0000_0000, 2'h0);
		op_demand <= 16'h0001;
		repeat (8) @(posedge aclk);
		`CHK(irq, 1'b0);
		axi_read(8'h10, 32'h0000_0004, 32'h0000_0007, 2'h0);
		$display("test activity and interrupt done");
		for (int i = 0; i < 4; i++) begin
			axi_write(8'h08, 32'(op_set[i]), 2'h0);
			axi_write(8'h04, 32'(pwr_set[i]), 2'h0);
			wait_modes(pwr_set[i], op_exp[i]);
			`CHK({power_mode, operating_mode}, {pwr_set[i], op_exp[i]});
		end
		axi_read(8'h10, 32'h0000_0003, 32'h0000_0003, 2'h0);
		axi_write(8'h04, 32'h0000_0006, 2'h0);
		repeat (5) @(posedge aclk);
		`CHK(power_mode, 4'h8);
		$display("test policies done");
		axi_write(8'h18, 32'h0000_0001, 2'h0);
		axi_read(8'h0c, 32'h0000_0100, 32'h0000_0100, 2'h0);
		axi_write(8'h04, 32'h0000_0000, 2'h0);
		repeat (5) @(posedge aclk);
		`CHK(power_mode, 4'h8);
		axi_write(8'h18, 32'h0000_0000, 2'h0);
		axi_write(8'h04, 32'h0000_0000, 2'h0);
		wait_modes(4'h0, 4'h4);
		`CHK(power_mode, 4'h0);
		$display("test lock done");
		close_out;
	end
endmodule : power_policy_config_params_tb
